// ---- design/stc_pkg.sv ----
package stc_pkg;
	// line rate codes
	typedef enum logic [2:0] {
		STC_RATE_STS1,
		STC_RATE_STS3,
		STC_RATE_OC1,
		STC_RATE_OC3,
		STC_RATE_OC12,
		STC_RATE_DS1,
		STC_RATE_DS3
	} stc_rate_t;

	// payload mapping codes
	typedef enum logic [1:0] {
		STC_MAP_BULK_EQ,
		STC_MAP_BULK_UNEQ,
		STC_MAP_DS3,
		STC_MAP_VT15
	} stc_map_t;

	// transmit clock sources
	typedef enum logic [1:0] {
		STC_CLK_INTERNAL,
		STC_CLK_RECOVERED,
		STC_CLK_EXTERNAL
	} stc_clk_t;

	// linkage modes
	typedef enum logic [1:0] {
		STC_LINK_SEPARATE,
		STC_LINK_COUPLED,
		STC_LINK_THROUGH
	} stc_link_t;

	// one side's signal settings
	typedef struct packed {
		stc_rate_t rate;
		stc_map_t mapping;
		logic optical;
	} stc_side_t;

	// transmit-only settings
	typedef struct packed {
		stc_clk_t clk_src;
		logic cross_connect_level;
		logic concat;
		logic [3:0] selected_sts_channel;
	} stc_txopt_t;

	localparam int STC_ADDR_W = 4;
	localparam logic [STC_ADDR_W-1:0] STC_OFF_TX_SIG = 4'h0;
	localparam logic [STC_ADDR_W-1:0] STC_OFF_RX_SIG = 4'h1;
	localparam logic [STC_ADDR_W-1:0] STC_OFF_TX_OPT = 4'h2;
	localparam logic [STC_ADDR_W-1:0] STC_OFF_LINK = 4'h3;
	localparam logic [STC_ADDR_W-1:0] STC_OFF_STATUS = 4'h4;

	localparam int STC_SIDE_W = $bits(stc_side_t);
	localparam int STC_OPT_W = $bits(stc_txopt_t);

	// reset values
	localparam stc_side_t STC_SIDE_RST = '{STC_RATE_STS1, STC_MAP_BULK_EQ, 1'b0};
	localparam stc_txopt_t STC_OPT_RST = '{STC_CLK_INTERNAL, 1'b0, 1'b0, 4'h1};

	// sts channel counts per rate
	localparam logic [3:0] STC_STS_ONE = 4'h1;
	localparam logic [3:0] STC_STS_THREE = 4'h3;
	localparam logic [3:0] STC_STS_TWELVE = 4'hc;

	// status bit positions
	localparam int STC_ST_COUPLED = 0;
	localparam int STC_ST_THROUGH = 1;
	localparam int STC_ST_REJECT = 2;
	localparam int STC_ST_HIDE = 3;

	// link register fields: mode in the low bits, requesting side above them
	localparam int STC_LINK_MODE_W = $bits(stc_link_t);
	localparam int STC_LINK_RX_MASTER = 2;
endpackage

// ---- design/stc_tx_config.sv ----
// What this block does
// [RL1] transmit rate accepts STS-1, STS-3, OC-1, OC-3, OC-12, DS1 or DS3
// [RL2] only one of sonet or tributary output enabled at a time
// [RL3] non-tributary transmit settings are independent of receive settings
// [RL4] writes giving DS1 transmit with DS3 receive are rejected
// [RL5] with tributaries, mappings must match or one side is bulk fill
// [RL6] while coupled, each side's change is copied to the other side
// [RL7] coupling from transmit copies tx to rx; from receive copies rx to tx
// [RL8] coupling status output follows linked or separate state
// [RL9] through mode retransmits received signal at received rate and content
// [RL10] through mode blocks overhead, pointer, timing edits and alarm insertion
// [RL11] through mode forwards without clock recovery
// [RL12] through mode raises link indication and hides transmit parameters
// [RL13] transmit clock is internal, recovered or external reference
// [RL14] electrical line level is high or cross-connect
// [RL15] STS-3/OC-3 layout is three STS-1 or one STS-3c
// [RL16] OC-12 layout is twelve STS-1 or four STS-3c
// [RL17] payload layout is ignored at other rates
// [RL18] above STS-1/OC-1 rate, an STS channel under test is held
// [RL19] channel under test limited to 1 up to channels carried by rate
// [RL20] leaving through mode restores generation in the chosen linkage state
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/10ps
module stc_tx_config
	import stc_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic [STC_ADDR_W-1:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	input wire logic EDIT_REQ,
	input wire logic INSERT_REQ,
	output stc_side_t TX_SIG,
	output stc_side_t RX_SIG,
	output stc_txopt_t TX_OPT,
	output logic [1:0] TX_PAYLOAD_SEL,
	output logic SONET_OUT_EN,
	output logic TRIB_OUT_EN,
	output logic THROUGH_EN,
	output logic CLK_RECOVERY_EN,
	output logic EDIT_GRANT,
	output logic INSERT_GRANT,
	output logic COUPLED,
	output logic TX_PARAMS_HIDDEN,
	output logic CONFIG_REJECT
);

	stc_side_t tx_reg, tx_next, rx_reg, rx_next;
	stc_txopt_t opt_reg, opt_next;
	stc_link_t link_reg, link_next;
	logic reject_reg, reject_next;
	logic [15:0] rdata_reg;

	logic wr_tx, wr_rx, wr_opt, wr_link;
	stc_side_t wtx, wrx;
	stc_txopt_t wopt;
	logic through;
	logic [STC_LINK_MODE_W-1:0] wmode;
	logic wmaster;

	assign wr_tx = WR && (ADDR == STC_OFF_TX_SIG);
	assign wr_rx = WR && (ADDR == STC_OFF_RX_SIG);
	assign wr_opt = WR && (ADDR == STC_OFF_TX_OPT);
	assign wr_link = WR && (ADDR == STC_OFF_LINK);
	assign wtx = stc_side_t'(WDATA[STC_SIDE_W-1:0]);
	assign wrx = stc_side_t'(WDATA[STC_SIDE_W-1:0]);
	assign wopt = stc_txopt_t'(WDATA[STC_OPT_W-1:0]);
	assign through = (link_reg == STC_LINK_THROUGH);
	// link write fields: requested mode and whether the receive side asked
	assign wmode = WDATA[STC_LINK_MODE_W-1:0];
	assign wmaster = WDATA[STC_LINK_RX_MASTER];

	function automatic logic is_trib(input stc_rate_t r);
		return (r == STC_RATE_DS1) || (r == STC_RATE_DS3);
	endfunction

	function automatic logic is_bulk(input stc_map_t m);
		return (m == STC_MAP_BULK_EQ) || (m == STC_MAP_BULK_UNEQ);
	endfunction

	function automatic logic rate_ok(input stc_rate_t r);
		return r inside {STC_RATE_STS1, STC_RATE_STS3, STC_RATE_OC1, STC_RATE_OC3,
			STC_RATE_OC12, STC_RATE_DS1, STC_RATE_DS3};
	endfunction

	// a side carries ds1 at that rate or mapped into a vt1.5
	function automatic logic has_ds1(input stc_side_t s);
		return (s.rate == STC_RATE_DS1) || (s.mapping == STC_MAP_VT15);
	endfunction

	// a side carries ds3 at that rate or mapped into the sts payload
	function automatic logic has_ds3(input stc_side_t s);
		return (s.rate == STC_RATE_DS3) || (s.mapping == STC_MAP_DS3);
	endfunction

	// pair legality between transmit and receive settings
	function automatic logic pair_ok(input stc_side_t t, input stc_side_t r);
		logic trib;
		logic map_ok;
		trib = is_trib(t.rate) || is_trib(r.rate) || !is_bulk(t.mapping) ||
			!is_bulk(r.mapping);
		map_ok = (t.mapping == r.mapping) || is_bulk(t.mapping) || is_bulk(r.mapping);
		// [RL4] no ds1 over ds3
		if (has_ds1(t) && has_ds3(r)) begin
			return 1'b0;
		end
		// [RL5] mapping match rule
		if (trib && !map_ok) begin
			return 1'b0;
		end
		return rate_ok(t.rate) && rate_ok(r.rate);
	endfunction

	// number of sts-1 channels carried at a rate
	function automatic logic [3:0] sts_count(input stc_rate_t r);
		unique case (r)
			STC_RATE_STS3, STC_RATE_OC3: return STC_STS_THREE;
			STC_RATE_OC12: return STC_STS_TWELVE;
			default: return STC_STS_ONE;
		endcase
	endfunction

	// settings update: coupling copies, legality check, through-mode freeze
	always_comb begin
		tx_next = tx_reg;
		rx_next = rx_reg;
		opt_next = opt_reg;
		link_next = link_reg;
		reject_next = reject_reg;
		if (wr_link) begin
			link_next = stc_link_t'(wmode);
			// [RL7] master side on entry
			if ((wmode == STC_LINK_COUPLED) && (link_reg != STC_LINK_COUPLED)) begin
				if (wmaster) begin
					tx_next = rx_reg;
				end else begin
					rx_next = tx_reg;
				end
			end
			// undefined mode code leaves the linkage unchanged
			if (wmode > STC_LINK_THROUGH) begin
				link_next = link_reg;
			end
			reject_next = 1'b0;
		end else if ((wr_tx || wr_rx) && !through) begin
			// [RL6] mirror while coupled
			if (wr_tx) begin
				tx_next = wtx;
				if (link_reg == STC_LINK_COUPLED) begin
					rx_next = wtx;
				end
			end else begin
				rx_next = wrx;
				if (link_reg == STC_LINK_COUPLED) begin
					tx_next = wrx;
				end
			end
			// [RL1] [RL3] checked per pair
			reject_next = !pair_ok(tx_next, rx_next);
			if (reject_next) begin
				tx_next = tx_reg;
				rx_next = rx_reg;
			end
		end else if (wr_opt && !through) begin
			// [RL13] clock source legal
			if (!(wopt.clk_src inside {STC_CLK_INTERNAL, STC_CLK_RECOVERED,
				STC_CLK_EXTERNAL})) begin
				reject_next = 1'b1;
			end else begin
				opt_next = wopt;
				reject_next = 1'b0;
			end
		end else if (wr_rx && through) begin
			// receive stays editable in through mode
			rx_next = wrx;
			reject_next = !pair_ok(tx_reg, wrx);
			if (reject_next) begin
				rx_next = rx_reg;
			end
		end else if ((wr_tx || wr_opt) && through) begin
			// [RL10] transmit edits refused
			reject_next = 1'b1;
		end
		// [RL19] clamp channel under test
		if (opt_next.selected_sts_channel == 4'h0) begin
			opt_next.selected_sts_channel = STC_STS_ONE;
		end else if (opt_next.selected_sts_channel > sts_count(tx_next.rate)) begin
			opt_next.selected_sts_channel = sts_count(tx_next.rate);
		end
	end

	// settings registers
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			tx_reg <= STC_SIDE_RST;
			rx_reg <= STC_SIDE_RST;
			opt_reg <= STC_OPT_RST;
			link_reg <= STC_LINK_SEPARATE;
			reject_reg <= 1'b0;
		end else begin
			tx_reg <= tx_next;
			rx_reg <= rx_next;
			opt_reg <= opt_next;
			link_reg <= link_next;
			reject_reg <= reject_next;
		end
	end

	// effective transmit configuration and datapath controls
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			TX_SIG <= STC_SIDE_RST;
			RX_SIG <= STC_SIDE_RST;
			TX_OPT <= STC_OPT_RST;
			TX_PAYLOAD_SEL <= 2'h0;
			SONET_OUT_EN <= 1'b0;
			TRIB_OUT_EN <= 1'b0;
			THROUGH_EN <= 1'b0;
			CLK_RECOVERY_EN <= 1'b0;
			COUPLED <= 1'b0;
			TX_PARAMS_HIDDEN <= 1'b0;
			CONFIG_REJECT <= 1'b0;
		end else begin
			// [RL9] through uses received signal
			TX_SIG <= through ? rx_reg : tx_reg;
			RX_SIG <= rx_reg;
			TX_OPT <= opt_reg;
			// [RL15] [RL16] [RL17] layout only at 3 and 12 channel rates
			TX_PAYLOAD_SEL <= (sts_count(tx_reg.rate) == STC_STS_ONE) ? 2'h0 :
				{sts_count(tx_reg.rate) == STC_STS_TWELVE, opt_reg.concat};
			// [RL18] channel held only above basic rate
			if (sts_count(tx_reg.rate) == STC_STS_ONE) begin
				TX_OPT.selected_sts_channel <= STC_STS_ONE;
			end
			// [RL14] level meaningful only electrically
			TX_OPT.cross_connect_level <= opt_reg.cross_connect_level && !tx_reg.optical;
			// [RL2] exclusive outputs
			SONET_OUT_EN <= !is_trib(through ? rx_reg.rate : tx_reg.rate);
			TRIB_OUT_EN <= is_trib(through ? rx_reg.rate : tx_reg.rate);
			THROUGH_EN <= through;
			// [RL11] no recovery on pass-through path
			CLK_RECOVERY_EN <= !through && (opt_reg.clk_src == STC_CLK_RECOVERED);
			// [RL8] coupling visible
			COUPLED <= (link_reg == STC_LINK_COUPLED);
			// [RL12] link indication and hide
			TX_PARAMS_HIDDEN <= through;
			CONFIG_REJECT <= reject_reg;
		end
	end

	// [RL10] insertion and overhead edit gating; a late request is dropped, not queued
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			EDIT_GRANT <= 1'b0;
			INSERT_GRANT <= 1'b0;
		end else begin
			EDIT_GRANT <= EDIT_REQ && !through;
			INSERT_GRANT <= INSERT_REQ && !through;
		end
	end

	// read port, data valid one cycle after the strobe
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			rdata_reg <= 16'h0000;
		end else if (RD) begin
			unique case (ADDR)
				STC_OFF_TX_SIG: rdata_reg <= 16'(tx_reg);
				STC_OFF_RX_SIG: rdata_reg <= 16'(rx_reg);
				STC_OFF_TX_OPT: rdata_reg <= 16'(opt_reg);
				STC_OFF_LINK: rdata_reg <= 16'(link_reg);
				STC_OFF_STATUS: begin
					rdata_reg <= 16'h0000;
					rdata_reg[STC_ST_COUPLED] <= (link_reg == STC_LINK_COUPLED);
					rdata_reg[STC_ST_THROUGH] <= through;
					rdata_reg[STC_ST_REJECT] <= reject_reg;
					rdata_reg[STC_ST_HIDE] <= through;
				end
				default: rdata_reg <= 16'h0000;
			endcase
		end
	end
	assign RDATA = rdata_reg;

	// outputs exclusive
	out_excl_a: assert property (@(posedge CLOCK) disable iff (RST) // [RL2]
		!(SONET_OUT_EN && TRIB_OUT_EN))
		else $error("sonet and tributary outputs both enabled");

	// ds1 over ds3 never held
	no_ds1ds3_a: assert property (@(posedge CLOCK) disable iff (RST) // [RL4]
		!((tx_reg.rate == STC_RATE_DS1) && (rx_reg.rate == STC_RATE_DS3)))
		else $error("ds1 transmit with ds3 receive held");

	// coupled copy from transmit
	copy_tx_a: assert property (@(posedge CLOCK) disable iff (RST) // [RL6]
		(wr_tx && link_reg == STC_LINK_COUPLED && !through) ##1 !reject_reg |->
		rx_reg == tx_reg)
		else $error("coupled transmit change not mirrored");

	// entry from receive side
	entry_rx_a: assert property (@(posedge CLOCK) disable iff (RST) // [RL7]
		(wr_link && wmode == STC_LINK_COUPLED && wmaster &&
		link_reg != STC_LINK_COUPLED) |=> tx_reg == $past(rx_reg))
		else $error("receive-side coupling did not copy rx to tx");

	// status follows link
	couple_stat_a: assert property (@(posedge CLOCK) disable iff (RST) // [RL8]
		COUPLED == ($past(link_reg) == STC_LINK_COUPLED))
		else $error("coupling status stale");

	// insertion blocked in through
	insert_block_a: assert property (@(posedge CLOCK) disable iff (RST) // [RL10]
		through |=> !INSERT_GRANT && !EDIT_GRANT)
		else $error("insertion granted in through mode");

	// no recovery in through
	no_recov_a: assert property (@(posedge CLOCK) disable iff (RST) // [RL11]
		THROUGH_EN |-> !CLK_RECOVERY_EN)
		else $error("clock recovery on while passing through");

	// hidden parameters track through
	hide_params_a: assert property (@(posedge CLOCK) disable iff (RST) // [RL12]
		through |=> TX_PARAMS_HIDDEN && THROUGH_EN)
		else $error("through indication missing");

	// channel bound
	sts_range_a: assert property (@(posedge CLOCK) disable iff (RST) // [RL19]
		opt_reg.selected_sts_channel >= STC_STS_ONE &&
		opt_reg.selected_sts_channel <= sts_count(tx_reg.rate))
		else $error("sts channel out of range");

	// through mode sends the receive settings
	thru_copy_a: assert property (@(posedge CLOCK) disable iff (RST) // [RL9]
		through |=> TX_SIG == $past(rx_reg))
		else $error("through output does not follow receive settings");

	// outside through mode the own transmit settings go out again
	own_tx_a: assert property (@(posedge CLOCK) disable iff (RST) // [RL20]
		!through |=> TX_SIG == $past(tx_reg))
		else $error("transmit settings not restored outside through mode");

	// a transmit write in through mode is refused and leaves nothing behind
	thru_refuse_a: assert property (@(posedge CLOCK) disable iff (RST) // [RL10]
		(wr_tx && through) |=> reject_reg && (tx_reg == $past(tx_reg)))
		else $error("transmit write accepted in through mode");

	// only the three defined clock sources are ever held
	clk_src_a: assert property (@(posedge CLOCK) disable iff (RST) // [RL13]
		opt_reg.clk_src inside {STC_CLK_INTERNAL, STC_CLK_RECOVERED, STC_CLK_EXTERNAL})
		else $error("illegal transmit clock source held");

	// payload layout stays neutral at one-channel rates
	layout_idle_a: assert property (@(posedge CLOCK) disable iff (RST) // [RL17]
		(sts_count(tx_reg.rate) == STC_STS_ONE) |=> TX_PAYLOAD_SEL == 2'h0)
		else $error("payload layout applied at a single-channel rate");

endmodule

// ---- dv/stc_far_model.sv ----
`timescale 1ns/10ps
module stc_far_model
	import stc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic ask,
	output logic edit_req,
	output logic insert_req,
	input wire logic edit_grant,
	input wire logic insert_grant,
	output logic served
);
	// the datapath raises both requests together and keeps them as levels
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			edit_req <= 1'b0;
			insert_req <= 1'b0;
		end else begin
			edit_req <= ask;
			insert_req <= ask;
		end
	end

	// served only when both grants came back, so a half answer shows up
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			served <= 1'b0;
		end else begin
			served <= edit_grant & insert_grant;
		end
	end
endmodule

// ---- dv/stc_tx_config_bench.sv ----
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module stc_tx_config_bench
	import stc_pkg::*;
;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic ask = 1'b0;
	logic [STC_ADDR_W-1:0] addr = '0;
	logic [15:0] wdata = '0;
	logic [15:0] rdata;
	logic [15:0] rd_val;
	logic edit_req, insert_req, sonet_en, trib_en, through, clk_rec;
	logic edit_gnt, insert_gnt, coupled, hidden, cfg_rej, served;
	logic [1:0] pay_sel;
	stc_side_t tx_sig, rx_sig;
	stc_txopt_t tx_opt;
	int miscompares = 0;
	int n_tests = 0;
	int cycles = 0;

	always #12.5 clock = ~clock;

	stc_tx_config dut (.CLOCK(clock), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
		.RD(rd_s), .RDATA(rdata), .EDIT_REQ(edit_req), .INSERT_REQ(insert_req),
		.TX_SIG(tx_sig), .RX_SIG(rx_sig), .TX_OPT(tx_opt), .TX_PAYLOAD_SEL(pay_sel),
		.SONET_OUT_EN(sonet_en), .TRIB_OUT_EN(trib_en), .THROUGH_EN(through),
		.CLK_RECOVERY_EN(clk_rec), .EDIT_GRANT(edit_gnt), .INSERT_GRANT(insert_gnt),
		.COUPLED(coupled), .TX_PARAMS_HIDDEN(hidden), .CONFIG_REJECT(cfg_rej));

	stc_far_model far (.clock(clock), .rst(rst), .ask(ask), .edit_req(edit_req),
		.insert_req(insert_req), .edit_grant(edit_gnt), .insert_grant(insert_gnt),
		.served(served));

	// the whole run needs well under a thousand cycles; this catches a hang
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			summarize();
		end
	end

	function automatic stc_side_t mk(stc_rate_t r, stc_map_t m, logic o);
		return '{r, m, o};
	endfunction

	function automatic logic [15:0] sw(stc_rate_t r, stc_map_t m, logic o);
		return {10'h0, mk(r, m, o)};
	endfunction

	function automatic logic [15:0] ow(stc_clk_t c, logic x, logic k, logic [3:0] n);
		return {8'h0, c, x, k, n};
	endfunction

	// one write strobe, then wait until the outputs have followed
	task automatic wreg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clock);
		wr_s <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
	endtask

	// read data stand from the cycle after the strobe until the next read
	task automatic rreg(input logic [3:0] a);
		@(posedge clock);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clock);
		rd_s <= 1'b0;
		#1;
		rd_val = rdata;
	endtask

	task automatic t_reset();
		`CHK(tx_sig, STC_SIDE_RST)
		`CHK(tx_opt, STC_OPT_RST)
		`CHK(sonet_en, 1'b1)
		`CHK(trib_en, 1'b0)
		rreg(STC_OFF_STATUS);
		`CHK(rd_val, 16'h0000)
	endtask

	task automatic t_rates();
		for (int i = 0; i < 7; i++) begin
			wreg(STC_OFF_TX_SIG, sw(stc_rate_t'(i), STC_MAP_BULK_EQ, 1'b0));
			`CHK(tx_sig.rate, stc_rate_t'(i))
			`CHK(sonet_en, logic'(i < 5))
			`CHK(trib_en, logic'(i >= 5))
		end
		wreg(STC_OFF_TX_SIG, sw(STC_RATE_OC3, STC_MAP_BULK_EQ, 1'b1));
		`CHK(tx_sig, mk(STC_RATE_OC3, STC_MAP_BULK_EQ, 1'b1))
		`CHK(rx_sig, STC_SIDE_RST)
	endtask

	task automatic t_reject();
		wreg(STC_OFF_RX_SIG, sw(STC_RATE_DS3, STC_MAP_BULK_EQ, 1'b0));
		wreg(STC_OFF_TX_SIG, sw(STC_RATE_DS1, STC_MAP_BULK_EQ, 1'b0));
		`CHK(cfg_rej, 1'b1)
		`CHK(tx_sig, mk(STC_RATE_OC3, STC_MAP_BULK_EQ, 1'b1))
		wreg(STC_OFF_RX_SIG, sw(STC_RATE_OC12, STC_MAP_DS3, 1'b1));
		wreg(STC_OFF_TX_SIG, sw(STC_RATE_DS1, STC_MAP_BULK_EQ, 1'b0));
		`CHK(cfg_rej, 1'b1)
		`CHK(tx_sig, mk(STC_RATE_OC3, STC_MAP_BULK_EQ, 1'b1))
		wreg(STC_OFF_TX_SIG, sw(STC_RATE_OC3, STC_MAP_VT15, 1'b1));
		`CHK(cfg_rej, 1'b1)
		wreg(STC_OFF_TX_SIG, sw(STC_RATE_OC3, STC_MAP_BULK_UNEQ, 1'b1));
		`CHK(cfg_rej, 1'b0)
		wreg(STC_OFF_TX_SIG, sw(STC_RATE_OC12, STC_MAP_DS3, 1'b0));
		`CHK(tx_sig, mk(STC_RATE_OC12, STC_MAP_DS3, 1'b0))
		wreg(STC_OFF_TX_OPT, 16'h00c1);
		rreg(STC_OFF_STATUS);
		`CHK(rd_val[STC_ST_REJECT], 1'b1)
	endtask

	task automatic t_couple();
		wreg(STC_OFF_TX_SIG, sw(STC_RATE_OC12, STC_MAP_BULK_EQ, 1'b1));
		wreg(STC_OFF_LINK, 16'h0001);
		`CHK(rx_sig, mk(STC_RATE_OC12, STC_MAP_BULK_EQ, 1'b1))
		`CHK(coupled, 1'b1)
		wreg(STC_OFF_RX_SIG, sw(STC_RATE_STS3, STC_MAP_BULK_EQ, 1'b0));
		`CHK(tx_sig, mk(STC_RATE_STS3, STC_MAP_BULK_EQ, 1'b0))
		wreg(STC_OFF_TX_SIG, sw(STC_RATE_OC1, STC_MAP_BULK_UNEQ, 1'b1));
		`CHK(rx_sig, mk(STC_RATE_OC1, STC_MAP_BULK_UNEQ, 1'b1))
		wreg(STC_OFF_LINK, 16'h0000);
		`CHK(coupled, 1'b0)
		wreg(STC_OFF_RX_SIG, sw(STC_RATE_STS1, STC_MAP_BULK_EQ, 1'b0));
		`CHK(tx_sig, mk(STC_RATE_OC1, STC_MAP_BULK_UNEQ, 1'b1))
		wreg(STC_OFF_LINK, 16'h0005);
		`CHK(tx_sig, mk(STC_RATE_STS1, STC_MAP_BULK_EQ, 1'b0))
		rreg(STC_OFF_STATUS);
		`CHK(rd_val[STC_ST_COUPLED], 1'b1)
		wreg(STC_OFF_LINK, 16'h0000);
	endtask

	task automatic t_through();
		wreg(STC_OFF_TX_SIG, sw(STC_RATE_OC12, STC_MAP_BULK_EQ, 1'b1));
		wreg(STC_OFF_TX_OPT, ow(STC_CLK_RECOVERED, 1'b0, 1'b0, 4'h1));
		`CHK(clk_rec, 1'b1)
		wreg(STC_OFF_RX_SIG, sw(STC_RATE_OC3, STC_MAP_BULK_EQ, 1'b1));
		ask <= 1'b1;
		wreg(STC_OFF_LINK, 16'h0002);
		`CHK(tx_sig, mk(STC_RATE_OC3, STC_MAP_BULK_EQ, 1'b1))
		`CHK(through, 1'b1)
		`CHK(hidden, 1'b1)
		`CHK(clk_rec, 1'b0)
		`CHK(edit_gnt, 1'b0)
		`CHK(insert_gnt, 1'b0)
		wreg(STC_OFF_TX_SIG, sw(STC_RATE_STS3, STC_MAP_BULK_EQ, 1'b0));
		`CHK(cfg_rej, 1'b1)
		`CHK(tx_sig, mk(STC_RATE_OC3, STC_MAP_BULK_EQ, 1'b1))
		wreg(STC_OFF_LINK, 16'h0000);
		`CHK(through, 1'b0)
		`CHK(hidden, 1'b0)
		`CHK(tx_sig, mk(STC_RATE_OC12, STC_MAP_BULK_EQ, 1'b1))
		`CHK(served, 1'b1)
		`CHK(clk_rec, 1'b1)
		ask <= 1'b0;
	endtask

	task automatic t_opts();
		wreg(STC_OFF_RX_SIG, sw(STC_RATE_STS1, STC_MAP_BULK_EQ, 1'b0));
		wreg(STC_OFF_TX_SIG, sw(STC_RATE_OC12, STC_MAP_BULK_EQ, 1'b0));
		wreg(STC_OFF_TX_OPT, ow(STC_CLK_EXTERNAL, 1'b1, 1'b1, 4'hf));
		`CHK(tx_opt.selected_sts_channel, 4'hc)
		`CHK(pay_sel, 2'b11)
		`CHK(tx_opt.clk_src, STC_CLK_EXTERNAL)
		`CHK(tx_opt.cross_connect_level, 1'b1)
		wreg(STC_OFF_TX_OPT, ow(STC_CLK_INTERNAL, 1'b0, 1'b0, 4'hc));
		`CHK(pay_sel, 2'b10)
		`CHK(tx_opt.selected_sts_channel, 4'hc)
		wreg(STC_OFF_TX_SIG, sw(STC_RATE_OC3, STC_MAP_BULK_EQ, 1'b1));
		wreg(STC_OFF_TX_OPT, ow(STC_CLK_INTERNAL, 1'b1, 1'b1, 4'h2));
		`CHK(pay_sel, 2'b01)
		`CHK(tx_opt.selected_sts_channel, 4'h2)
		`CHK(tx_opt.cross_connect_level, 1'b0)
		wreg(STC_OFF_TX_SIG, sw(STC_RATE_STS1, STC_MAP_BULK_EQ, 1'b0));
		wreg(STC_OFF_TX_OPT, ow(STC_CLK_INTERNAL, 1'b0, 1'b1, 4'h3));
		`CHK(pay_sel, 2'b00)
		`CHK(tx_opt.selected_sts_channel, 4'h1)
	endtask

	// one place decides the verdict and ends the run
	task automatic summarize();
		$display("compares %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		t_reset();
		t_rates();
		t_reject();
		t_couple();
		t_through();
		t_opts();
		summarize();
	end
endmodule
